// *** verilog/static_memory_controller.sv ***
// static memory controller: system request to external byte-wide bus, with nand glue
// Notes on behaviour
// - four selects, 24-bit address, 8-bit data
// - each select decodes its own 16 Mbyte window
// - address driven unchanged, small memories repeat
// - low wait input stretches the current access
// - slow clock mode uses fixed strobe waveforms
// - page mode reads, page 4 to 32 bytes
// - data scrambled with key, no wait states
// - word, halfword and byte transfers accepted
// - per-select setup, pulse, hold and float timing
// - separate active-low read, write, select outputs
// - nand select copies strobes to nand pins
// - nand strobes drop outside nand address space
// - nand mode chosen per chip select
// - A22 and A21 act as latch enables
// - timings counted in whole clocks per select
// - read data latched on strobe or select rise
module static_memory_controller (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // system request
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [1:0] i_size,
    input wire logic [25:0] i_addr,
    input wire logic [31:0] i_wdata,
    output logic o_ready,
    output logic [31:0] o_rdata,
    // per-select configuration, timings packed as four fields of six bits
    input wire logic [23:0] i_rd_setup,
    input wire logic [23:0] i_rd_pulse,
    input wire logic [23:0] i_cs_rd_setup,
    input wire logic [23:0] i_cs_rd_pulse,
    input wire logic [23:0] i_rd_cycle,
    input wire logic [23:0] i_wr_setup,
    input wire logic [23:0] i_wr_pulse,
    input wire logic [23:0] i_cs_wr_setup,
    input wire logic [23:0] i_cs_wr_pulse,
    input wire logic [23:0] i_wr_cycle,
    input wire logic [23:0] i_float_time,
    input wire logic [3:0] i_read_mode,
    input wire logic [3:0] i_page_en,
    input wire logic [7:0] i_page_size,
    input wire logic [3:0] i_nand_chip_select_config,
    // global configuration
    input wire logic i_slow_clock_mode,
    input wire logic i_scramble_en,
    input wire logic [7:0] i_scramble_key,
    // external pins
    output logic [3:0] o_chip_select_lines_n,
    output logic o_read_strobe_n,
    output logic o_write_strobe_n,
    output logic [23:0] o_addr,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe_n,
    input wire logic i_wait_request_in_n,
    output logic o_nand_chip_select_out_n,
    output logic o_nand_output_enable_n,
    output logic o_nand_write_enable_n,
    output logic o_nand_ale,
    output logic o_nand_cle
);
    static_memory_controller_pkg::smc_state_t state_q;
    static_memory_controller_pkg::smc_state_t state_d;
    logic [1:0] cs_q;
    logic [1:0] cs_d;
    logic we_q;
    logic we_d;
    logic [23:0] addr_q;
    logic [23:0] addr_d;
    logic [31:0] wdata_q;
    logic [31:0] wdata_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0] byte_q;
    logic [1:0] byte_d;
    logic [1:0] nbytes_q;
    logic [1:0] nbytes_d;
    logic [5:0] float_q;
    logic [5:0] float_d;
    logic [1:0] float_cs_q;
    logic [1:0] float_cs_d;
    logic page_hit_q;
    logic page_hit_d;
    logic start;
    logic [5:0] t_sset;
    logic [5:0] t_spul;
    logic [5:0] t_cset;
    logic [5:0] t_cpul;
    logic [5:0] t_cyc;
    logic g_busy;
    logic g_last;
    logic g_strb_on;
    logic g_cs_on;
    logic g_strb_rise;
    logic g_cs_rise;
    logic latch_rd;
    logic [7:0] rd_byte;

    function automatic logic [5:0] field(input logic [23:0] v, input logic [1:0] i);
        field = v[6 * i +: 6];
    endfunction : field

    // scrambling is an xor with the key and the byte lane, so it adds no wait state
    function automatic logic [7:0] scram(input logic [7:0] d, input logic en,
                                         input logic [7:0] key, input logic [1:0] lane);
        scram = en ? (d ^ key ^ {6'h00, lane}) : d;
    endfunction : scram

    // page codes 4, 8, 16, 32 bytes give the offset mask width
    function automatic logic same_page(input logic [23:0] a, input logic [23:0] b,
                                       input logic [1:0] code);
        logic [23:0] mask;
        mask = 24'hff_ffff << (3'(code) + 3'h2);
        same_page = (a & mask) == (b & mask);
    endfunction : same_page

    always_comb begin
        // slow clock mode overrides the programmed waveform
        if (i_slow_clock_mode) begin
            t_sset = static_memory_controller_pkg::SLOW_SETUP;
            t_spul = static_memory_controller_pkg::SLOW_PULSE;
            t_cset = static_memory_controller_pkg::SLOW_SETUP;
            t_cpul = static_memory_controller_pkg::SLOW_PULSE;
            t_cyc = static_memory_controller_pkg::SLOW_CYCLE;
        end else if (we_q) begin
            t_sset = field(i_wr_setup, cs_q);
            t_spul = field(i_wr_pulse, cs_q);
            t_cset = field(i_cs_wr_setup, cs_q);
            t_cpul = field(i_cs_wr_pulse, cs_q);
            t_cyc = field(i_wr_cycle, cs_q);
        end else begin
            t_sset = field(i_rd_setup, cs_q);
            t_spul = field(i_rd_pulse, cs_q);
            t_cset = field(i_cs_rd_setup, cs_q);
            t_cpul = field(i_cs_rd_pulse, cs_q);
            t_cyc = field(i_rd_cycle, cs_q);
        end
        // page hit: later bytes of a page read skip the setup phase
        if (page_hit_q && !we_q && !i_slow_clock_mode) begin
            t_sset = 6'h00;
            t_cset = 6'h00;
            t_cyc = (t_spul > t_cpul) ? t_spul : t_cpul;
        end
    end

    smc_strobe_gen u_gen (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_start(start),
        .i_wait_n(i_wait_request_in_n),
        .i_strb_setup(t_sset),
        .i_strb_pulse(t_spul),
        .i_cs_setup(t_cset),
        .i_cs_pulse(t_cpul),
        .i_cycle(t_cyc),
        .o_busy(g_busy),
        .o_last(g_last),
        .o_strb_on(g_strb_on),
        .o_cs_on(g_cs_on),
        .o_strb_rise(g_strb_rise),
        .o_cs_rise(g_cs_rise)
    );

    assign latch_rd = !we_q && (i_read_mode[cs_q] ? g_strb_rise : g_cs_rise);
    assign rd_byte = scram(i_data, i_scramble_en, i_scramble_key, byte_q);

    always_comb begin
        state_d = state_q;
        cs_d = cs_q;
        we_d = we_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        byte_d = byte_q;
        nbytes_d = nbytes_q;
        float_d = (float_q != 6'h00) ? float_q - 6'h01 : 6'h00;
        float_cs_d = float_cs_q;
        page_hit_d = page_hit_q;
        start = 1'b0;
        if (latch_rd) begin
            rdata_d[8 * byte_q +: 8] = rd_byte;
        end
        unique case (state_q)
            static_memory_controller_pkg::ST_IDLE: begin
                // a new select waits out the float time of the last read
                if (i_req && (float_q == 6'h00 || float_cs_q == i_addr[25:24])) begin
                    cs_d = i_addr[25:24];
                    we_d = i_we;
                    addr_d = i_addr[23:0];
                    wdata_d = i_wdata;
                    byte_d = 2'h0;
                    page_hit_d = 1'b0;
                    unique case (i_size)
                        static_memory_controller_pkg::SIZE_HALF: nbytes_d = 2'h1;
                        static_memory_controller_pkg::SIZE_WORD: nbytes_d = 2'h3;
                        default: nbytes_d = 2'h0;
                    endcase
                    start = 1'b1;
                    state_d = static_memory_controller_pkg::ST_RUN;
                end
            end
            static_memory_controller_pkg::ST_RUN: begin
                if (g_last) begin
                    if (byte_q == nbytes_q) begin
                        state_d = static_memory_controller_pkg::ST_DONE;
                        if (!we_q) begin
                            float_d = field(i_float_time, cs_q);
                            float_cs_d = cs_q;
                        end
                    end else begin
                        byte_d = byte_q + 2'h1;
                        addr_d = addr_q + 24'h00_0001;
                        page_hit_d = i_page_en[cs_q] && same_page(addr_q,
                            addr_q + 24'h00_0001, i_page_size[2 * cs_q +: 2]);
                        start = 1'b1;
                    end
                end
            end
            static_memory_controller_pkg::ST_DONE: begin
                state_d = static_memory_controller_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= static_memory_controller_pkg::ST_IDLE;
            cs_q <= 2'h0;
            we_q <= 1'b0;
            addr_q <= 24'h00_0000;
            wdata_q <= 32'h0000_0000;
            rdata_q <= static_memory_controller_pkg::RESET_RDATA;
            byte_q <= 2'h0;
            nbytes_q <= 2'h0;
            float_q <= 6'h00;
            float_cs_q <= 2'h0;
            page_hit_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cs_q <= cs_d;
            we_q <= we_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            byte_q <= byte_d;
            nbytes_q <= nbytes_d;
            float_q <= float_d;
            float_cs_q <= float_cs_d;
            page_hit_q <= page_hit_d;
        end
    end

    // pin drive
    always_comb begin
        o_chip_select_lines_n = 4'hf;
        if (g_busy && g_cs_on) begin
            o_chip_select_lines_n[cs_q] = 1'b0;
        end
        o_read_strobe_n = !(g_busy && g_strb_on && !we_q);
        o_write_strobe_n = !(g_busy && g_strb_on && we_q);
        o_data_oe_n = !(g_busy && we_q);
        o_data = scram(wdata_q[8 * byte_q +: 8], i_scramble_en, i_scramble_key,
                       byte_q);
        // nand glue follows the select configured for nand, per select
        o_nand_chip_select_out_n = !(g_busy && i_nand_chip_select_config[cs_q]
                                     && g_cs_on);
        o_nand_output_enable_n = !(g_busy && i_nand_chip_select_config[cs_q]
                                   && !o_read_strobe_n);
        o_nand_write_enable_n = !(g_busy && i_nand_chip_select_config[cs_q]
                                  && !o_write_strobe_n);
    end

    assign o_addr = addr_q;
    assign o_nand_ale = addr_q[static_memory_controller_pkg::NAND_ALE_BIT];
    assign o_nand_cle = addr_q[static_memory_controller_pkg::NAND_CLE_BIT];
    assign o_ready = (state_q == static_memory_controller_pkg::ST_DONE);
    assign o_rdata = rdata_q;

    AST_ONE_CS: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        $countones(~o_chip_select_lines_n) <= 1)
        else $error("more than one select active");
    AST_NAND_OUTSIDE: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        !i_nand_chip_select_config[cs_q] |-> (o_nand_output_enable_n &&
        o_nand_write_enable_n))
        else $error("nand strobe outside nand space");
    AST_NAND_COPY: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_nand_chip_select_config[cs_q] && g_busy) |->
        (o_nand_output_enable_n == o_read_strobe_n))
        else $error("nand output enable not copied");
    AST_NO_RW: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        !(!o_read_strobe_n && !o_write_strobe_n))
        else $error("read and write strobes together");
    AST_LATCH: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        latch_rd |=> (rdata_q[8 * $past(byte_q) +: 8] == $past(rd_byte)))
        else $error("read byte not latched");
    AST_ADDR_STEP: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (state_q == static_memory_controller_pkg::ST_RUN && g_last && byte_q != nbytes_q)
        |=> (o_addr == $past(o_addr) + 24'h00_0001))
        else $error("address did not step");
    AST_WR_DATA: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        !o_write_strobe_n |-> (!o_data_oe_n))
        else $error("data not driven during write");
    AST_WAIT_STRETCH: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (g_busy && !i_wait_request_in_n && !o_read_strobe_n) |=>
        (state_q == static_memory_controller_pkg::ST_RUN))
        else $error("access ended during wait");
    AST_DONE_PULSE: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        o_ready |=> !o_ready)
        else $error("ready held two cycles");
    CVR_READ: cover property (@(posedge i_clk_sys) o_ready && !we_q);
    CVR_WORD_WRITE: cover property (@(posedge i_clk_sys) o_ready && we_q && nbytes_q == 2'h3);
    CVR_NAND: cover property (@(posedge i_clk_sys) !o_nand_write_enable_n);
    CVR_PAGE: cover property (@(posedge i_clk_sys) page_hit_q && g_busy);
endmodule : static_memory_controller

// *** verilog/static_memory_controller_pkg.sv ***
// package: constants and types of the static memory controller
package static_memory_controller_pkg;
    localparam int NUM_CS = 4;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 8;
    localparam int SYS_ADDR_W = 26;
    localparam int TIM_W = 6;
    localparam int PAGE_W = 2;
    // transfer sizes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    // page size codes: 4, 8, 16, 32 bytes
    localparam logic [1:0] PAGE_4 = 2'h0;
    localparam logic [1:0] PAGE_32 = 2'h3;
    // fixed slow-clock waveform, in cycles
    localparam logic [5:0] SLOW_SETUP = 6'h01;
    localparam logic [5:0] SLOW_PULSE = 6'h01;
    localparam logic [5:0] SLOW_CYCLE = 6'h03;
    // nand latch enables sit on these address bits
    localparam int NAND_ALE_BIT = 22;
    localparam int NAND_CLE_BIT = 21;
    localparam logic [31:0] RESET_RDATA = 32'h0000_0000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_DONE = 3'b100
    } smc_state_t;
endpackage : static_memory_controller_pkg

// *** verilog/smc_strobe_gen.sv ***
// strobe generator: one byte cycle of strobes from setup, pulse and cycle counts
module smc_strobe_gen (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // control
    input wire logic i_start,
    input wire logic i_wait_n,
    input wire logic [5:0] i_strb_setup,
    input wire logic [5:0] i_strb_pulse,
    input wire logic [5:0] i_cs_setup,
    input wire logic [5:0] i_cs_pulse,
    input wire logic [5:0] i_cycle,
    // status
    output logic o_busy,
    output logic o_last,
    output logic o_strb_on,
    output logic o_cs_on,
    output logic o_strb_rise,
    output logic o_cs_rise
);
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic busy_q;
    logic busy_d;
    logic strb_in;
    logic cs_in;
    logic stretch;

    function automatic logic in_win(input logic [5:0] c, input logic [5:0] s,
                                    input logic [5:0] p);
        in_win = (c >= s) && (c < 6'(s + p));
    endfunction : in_win

    always_comb begin
        strb_in = in_win(cnt_q, i_strb_setup, i_strb_pulse);
        cs_in = in_win(cnt_q, i_cs_setup, i_cs_pulse);
        // hold the last pulse cycle while the device requests wait
        stretch = !i_wait_n && ((cnt_q == 6'(i_strb_setup + i_strb_pulse - 6'h01)) ||
                  (cnt_q == 6'(i_cs_setup + i_cs_pulse - 6'h01)));
        o_strb_rise = busy_q && !stretch &&
                      (cnt_q == 6'(i_strb_setup + i_strb_pulse - 6'h01));
        o_cs_rise = busy_q && !stretch &&
                    (cnt_q == 6'(i_cs_setup + i_cs_pulse - 6'h01));
        o_last = busy_q && !stretch && (cnt_q >= 6'(i_cycle - 6'h01));
        cnt_d = cnt_q;
        busy_d = busy_q;
        if (i_start) begin
            busy_d = 1'b1;
            cnt_d = 6'h00;
        end else if (busy_q && !stretch) begin
            if (o_last) begin
                busy_d = 1'b0;
            end else begin
                cnt_d = cnt_q + 6'h01;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= 6'h00;
            busy_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
        end
    end

    assign o_busy = busy_q;
    assign o_strb_on = busy_q && strb_in;
    assign o_cs_on = busy_q && cs_in;

    AST_WAIT_HOLDS: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (busy_q && stretch) |=> (cnt_q == $past(cnt_q)))
        else $error("count moved during wait");
    AST_CYCLE_LEN: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        o_last |-> (cnt_q >= 6'(i_cycle - 6'h01)))
        else $error("cycle ended early");
endmodule : smc_strobe_gen

// *** test/smc_ext_memory.sv ***
// bench model of an external byte-wide memory with a wait output
module smc_ext_memory (
    // clock
    input wire logic i_clk_sys,
    // controller pins
    input wire logic [3:0] i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [23:0] i_addr,
    input wire logic [7:0] i_data,
    input wire logic i_data_oe_n,
    // stall length in cycles
    input wire logic [3:0] i_stall,
    // answer
    output logic [7:0] o_data,
    output logic o_wait_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:1023];
    logic [7:0] last_q = 8'h00;
    logic [9:0] idx;
    logic sel;
    logic strb_q = 1'b1;
    int stall_cnt = 0;
    initial for (int i = 0; i < 1024; i++) mem[i] = 8'h00;
    // select pins drive the part enable directly, enable release tolerated
    // only eight address bits decoded, so content repeats in the window
    always_comb begin
        sel = ~&i_cs_n;
        idx = {~i_cs_n[3] ? 2'h3 : ~i_cs_n[2] ? 2'h2 : ~i_cs_n[1] ? 2'h1 : 2'h0, i_addr[7:0]};
    end
    // a released bus shows the inverse of the last value
    assign o_data = (sel && i_data_oe_n) ? mem[idx] : ~last_q;
    always @(posedge i_clk_sys) if (sel && i_data_oe_n) last_q <= mem[idx];
    // write strobe kept in its pin function; data taken at each rising clock edge during its low pulse
    always @(posedge i_clk_sys) if (sel && !i_wr_n) mem[idx] <= i_data;
    // wait held low for a set time after a strobe falls
    assign o_wait_n = (stall_cnt == 0);
    always @(posedge i_clk_sys) begin
        strb_q <= i_rd_n & i_wr_n;
        if (stall_cnt > 0) stall_cnt <= stall_cnt - 1;
        else if (strb_q && !(i_rd_n & i_wr_n)) stall_cnt <= int'(i_stall);
    end
endmodule : smc_ext_memory

// *** test/testbench.sv ***
// self-checking bench for the static memory controller
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic req = 1'b0;
    logic we = 1'b0;
    logic [1:0] size = 2'h0;
    logic [25:0] addr = 26'h0;
    logic [31:0] wdata = 32'h0;
    logic [23:0] cyc6 = {4{6'h04}};
    logic [3:0] rmode = 4'h0;
    logic [7:0] psize = 8'h00;
    logic [3:0] nand_cfg = 4'h0;
    logic slow = 1'b0;
    logic scr = 1'b0;
    logic [7:0] key = 8'h00;
    logic [3:0] stall = 4'h0;
    logic [3:0] pg = 4'h0;
    logic [23:0] flt = 24'h000000;
    logic ready, rd_n, wr_n, oe_n, wait_n, ncs_n, noe_n, nwe_n, ale, cle;
    logic [31:0] rdata;
    logic [3:0] cs_n;
    logic [23:0] xaddr;
    logic [7:0] din, dout;
    logic [7:0] bmem [int];
    int n_fail = 0;
    int comparisons = 0;
    int seed = 53483;

    // every pulse length programmed to one cycle or more
    static_memory_controller dut (
        .i_clk_sys(clk), .i_nrst(nrst), .i_req(req), .i_we(we), .i_size(size),
        .i_addr(addr), .i_wdata(wdata), .o_ready(ready), .o_rdata(rdata),
        .i_rd_setup({4{6'h01}}), .i_rd_pulse({4{6'h02}}), .i_cs_rd_setup({4{6'h01}}),
        .i_cs_rd_pulse({4{6'h03}}), .i_rd_cycle(cyc6), .i_wr_setup({4{6'h01}}),
        .i_wr_pulse({4{6'h02}}), .i_cs_wr_setup({4{6'h01}}), .i_cs_wr_pulse({4{6'h03}}),
        .i_wr_cycle(cyc6), .i_float_time(flt), .i_read_mode(rmode),
        .i_page_en(pg), .i_page_size(psize), .i_nand_chip_select_config(nand_cfg),
        .i_slow_clock_mode(slow), .i_scramble_en(scr), .i_scramble_key(key),
        .o_chip_select_lines_n(cs_n), .o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n),
        .o_addr(xaddr), .i_data(din), .o_data(dout), .o_data_oe_n(oe_n),
        .i_wait_request_in_n(wait_n), .o_nand_chip_select_out_n(ncs_n),
        .o_nand_output_enable_n(noe_n), .o_nand_write_enable_n(nwe_n),
        .o_nand_ale(ale), .o_nand_cle(cle)
    );

    smc_ext_memory mem_model (
        .i_clk_sys(clk), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr(xaddr),
        .i_data(dout), .i_data_oe_n(oe_n), .i_stall(stall), .o_data(din), .o_wait_n(wait_n)
    );

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic finish_test();
        if (n_fail == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one transfer; n counts edges from the request to the ready pulse
    task automatic xfer(input logic w, input logic [1:0] sz, input logic [25:0] a,
                        input logic [31:0] d, output logic [31:0] r, output int n);
        n = 0;
        @(posedge clk);
        #1;
        we = w;
        size = sz;
        addr = a;
        wdata = d;
        req = 1'b1;
        repeat (300) begin
            @(posedge clk);
            #1;
            n++;
            if (ready === 1'b1) break;
        end
        if (ready !== 1'b1) begin
            n_fail++;
            finish_test();
        end
        r = rdata;
        req = 1'b0;
    endtask : xfer

    // nand strobes follow the main strobes only on a nand select
    always @(negedge clk) begin
        if (nrst === 1'b1) begin
            check("nand_oe", noe_n, (|(~cs_n & nand_cfg)) ? rd_n : 1'b1);
            check("nand_we", nwe_n, (|(~cs_n & nand_cfg)) ? wr_n : 1'b1);
            check("nand_cs", ncs_n, (|(~cs_n & nand_cfg)) ? 1'b0 : 1'b1);
            check("ale", ale, xaddr[22]);
            check("cle", cle, xaddr[21]);
        end
    end

    // write then read back through a mirrored address, random size, select and timing
    task automatic rw(input int cs, input int a, input logic [1:0] sz, input int cyc_exp);
        int n, nb, rd_exp;
        logic [31:0] d, r, e, m;
        d = $random(seed);
        nb = 1 << sz;
        xfer(1'b1, sz, {cs[1:0], a[23:0]}, d, r, n);
        check("wr_cycles", n, cyc_exp * nb + 1);
        for (int k = 0; k < nb; k++) bmem[cs * 256 + ((a + k) & 255)] = d[8 * k +: 8];
        a = a ^ ($random(seed) & 32'h00ffff00);
        xfer(1'b0, sz, {cs[1:0], a[23:0]}, 32'h0, r, n);
        // later bytes of a page read skip setup and last the longer pulse, three here
        rd_exp = (pg[cs] && !slow) ? cyc_exp + 3 * (nb - 1) + 1 : cyc_exp * nb + 1;
        check("rd_cycles", n, rd_exp);
        e = 32'h0;
        for (int k = 0; k < nb; k++) e[8 * k +: 8] = bmem[cs * 256 + ((a + k) & 255)];
        m = (nb == 4) ? 32'hffffffff : (32'h1 << (8 * nb)) - 32'h1;
        check("rdata", r & m, e);
    endtask : rw

    initial begin
        logic [5:0] c;
        logic [31:0] r;
        int n;
        repeat (12) @(posedge clk);
        check("ready_rst", ready, 1'b0);
        check("pins_rst", {cs_n, rd_n, wr_n, oe_n}, 7'h7f);
        check("rdata_rst", rdata, 32'h0);
        #1;
        nrst = 1'b1;
        rmode = 4'($random(seed));
        psize = 8'($random(seed));
        for (int i = 0; i < 40; i++) begin
            nand_cfg = 4'($random(seed));
            pg = 4'($random(seed));
            c = 6'h04 + 6'($random(seed) & 3);
            cyc6 = {4{c}};
            rw($random(seed) & 3, $random(seed) & 32'h00fffff0,
               2'($unsigned($random(seed)) % 3), int'(c));
        end
        cyc6 = {4{6'h04}};
        stall = 4'h6;
        xfer(1'b0, 2'h0, 26'h0000010, 32'h0, r, n);
        check("wait_stretch", n, 11);
        stall = 4'h0;
        flt = {4{6'h03}};
        xfer(1'b0, 2'h0, 26'h0000010, 32'h0, r, n);
        xfer(1'b0, 2'h0, 26'h1000010, 32'h0, r, n);
        check("float_wait", n, 7);
        flt = 24'h000000;
        slow = 1'b1;
        rw(1, 32'h000120, 2'h2, 3);
        slow = 1'b0;
        scr = 1'b1;
        key = 8'($random(seed));
        xfer(1'b1, 2'h0, 26'h0000040, 32'h000000a5, r, n);
        check("scr_pin", mem_model.mem[10'h040], 8'ha5 ^ key);
        check("scr_cycles", n, 5);
        rw(0, 32'h000080, 2'h2, 4);
        scr = 1'b0;
        finish_test();
    end
endmodule : testbench
